// File: src/nsw_core.sv
// execution unit for the nibble swap and table read instructions
// assumes register file and program memory answer combinationally on sys_clk
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "nsw_regs.svh"
module nsw_core
  import nsw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire nswAxiReq_t  axiReq,
  output nswAxiRsp_t       axiRsp,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  output logic             instrReady,
  output logic [11:0]      fileAddr,
  output logic             fileRe,
  input  wire logic [7:0]  fileRdata,
  output logic [7:0]       fileWdata,
  output logic             fileWe,
  input  wire logic [11:0] idxBase,
  output logic [19:0]      pmWordAddr,
  output logic             pmRe,
  input  wire logic [15:0] pmRdata,
  output logic [7:0]       wreg,
  output logic             flagWe
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    nswPhase_t   st;
    logic [1:0]  q;
    logic [7:0]  f;
    logic        d;
    logic        a;
    logic [1:0]  adjCode;
    logic        ext;
    logic [20:0] ptr;
    logic [20:0] rdPtr;
    logic [7:0]  tableLatch;
    logic [7:0]  wreg;
    logic [3:0]  bankSel;
    logic [11:0] fAddr;
    logic        fRe;
    logic [7:0]  fWd;
    logic        fWe;
    logic        pmRe;
    logic [7:0]  src;
    logic [7:0]  res;
    logic        awGot;
    logic [7:0]  awAddr;
    logic        wGot;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } nswCore_t;

  nswCore_t s;
  nswCore_t next_s;

  logic       swapAcc;
  logic       tblAcc;
  logic [7:0] swpRef;
  logic [7:0] pmByte;
  logic       busy;

  // byte-lane merge for AXI write strobes
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : laneMerge

  // -------------------------------------------------------------
  // handshakes and decode
  // -------------------------------------------------------------
  assign busy       = (s.st != ST_IDLE);
  assign instrReady = !busy && (s.q == 2'd0);
  assign swapAcc    = instrReady && instrValid &&
                      (instrWord[15:10] == `NSW_OP_SWAP);
  assign tblAcc     = instrReady && instrValid &&
                      (instrWord[15:2] == `NSW_OP_TREAD);
  assign swpRef     = {fileRdata[3:0], fileRdata[7:4]};
  assign pmByte     = s.rdPtr[0] ? pmRdata[15:8] : pmRdata[7:0];

  // outputs straight from state flops
  assign fileAddr   = s.fAddr;
  assign fileRe     = s.fRe;
  assign fileWdata  = s.fWd;
  assign fileWe     = s.fWe;
  assign pmWordAddr = s.rdPtr[20:1];
  assign pmRe       = s.pmRe;
  assign wreg       = s.wreg;
  // neither instruction has a path to the status flags
  assign flagWe     = 1'b0;

  // AXI channel readies: one write and one read in flight
  always_comb begin
    axiRsp.awready = !s.awGot && !s.bValid;
    axiRsp.wready  = !s.wGot && !s.bValid;
    axiRsp.bvalid  = s.bValid;
    axiRsp.bresp   = s.bResp;
    axiRsp.arready = !s.rValid;
    axiRsp.rvalid  = s.rValid;
    axiRsp.rdata   = s.rData;
    axiRsp.rresp   = s.rResp;
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    logic [31:0] cur;
    cur    = 32'h0;
    next_s = s;
    next_s.q = s.q + 2'd1;

    // sequencer: quarter phases drive every step
    case (s.st)
      ST_IDLE: begin
        if (swapAcc) begin
          next_s.st = ST_SWAP;
          next_s.f  = instrWord[7:0];
          next_s.d  = instrWord[9];
          next_s.a  = instrWord[8];
          next_s.fRe = 1'b1; // read in Q2
          if (instrWord[8]) begin
            next_s.fAddr = {s.bankSel, instrWord[7:0]};
          end else if (s.ext && instrWord[7:0] <= `NSW_IDX_LIMIT) begin
            next_s.fAddr = idxBase + {4'h0, instrWord[7:0]};
          end else if (instrWord[7:0] < `NSW_ACC_SPLIT) begin
            next_s.fAddr = {4'h0, instrWord[7:0]};
          end else begin
            next_s.fAddr = {`NSW_SFR_PAGE, instrWord[7:0]};
          end
        end else if (tblAcc) begin
          next_s.st = ST_TBL1; // first cycle decodes; its Q4 raises pmRe and applies any pre-increment
          next_s.adjCode = instrWord[1:0];
        end
      end
      ST_SWAP: begin
        case (s.q)
          2'd1: begin
            next_s.src = fileRdata;
            next_s.fRe = 1'b0;
          end
          2'd2: begin
            next_s.res = {s.src[3:0], s.src[7:4]};
            next_s.fWd = {s.src[3:0], s.src[7:4]};
            next_s.fWe = s.d; // write lands on the Q4 edge
          end
          2'd3: begin
            next_s.fWe = 1'b0;
            if (!s.d) begin
              next_s.wreg = s.res;
            end
            next_s.st = ST_IDLE; // done within one cycle
          end
          default: begin
            next_s.fRe = s.fRe;
          end
        endcase
      end
      ST_TBL1: begin
        if (s.q == 2'd3) begin
          next_s.st   = ST_TBL2;
          next_s.pmRe = 1'b1;
          // pre-increment moves the pointer ahead of the read
          if (s.adjCode == 2'd3) begin
            next_s.ptr   = s.ptr + 21'd1;
            next_s.rdPtr = s.ptr + 21'd1;
          end else begin
            next_s.rdPtr = s.ptr;
          end
        end
      end
      ST_TBL2: begin
        case (s.q)
          2'd1: begin
            next_s.src  = pmByte; // program memory read in Q2
            next_s.pmRe = 1'b0;
          end
          2'd3: begin
            next_s.tableLatch = s.src; // latch written in Q4
            next_s.st     = ST_IDLE;
            // post variants adjust after the read, wrapping in 21 bits
            if (s.adjCode == 2'd1) begin
              next_s.ptr = s.ptr + 21'd1;
            end else if (s.adjCode == 2'd2) begin
              next_s.ptr = s.ptr - 21'd1;
            end
          end
          default: begin
            next_s.pmRe = s.pmRe;
          end
        endcase
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // AXI write: address and data may come in either order
    if (axiReq.awvalid && !s.awGot && !s.bValid) begin
      next_s.awGot  = 1'b1;
      next_s.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !s.wGot && !s.bValid) begin
      next_s.wGot  = 1'b1;
      next_s.wData = axiReq.wdata;
      next_s.wStrb = axiReq.wstrb;
    end
    // commit once both are held; registers the sequencer owns are
    // left alone while busy so an instruction never sees a torn value
    if (s.awGot && s.wGot) begin
      next_s.awGot  = 1'b0;
      next_s.wGot   = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = `NSW_RESP_OK;
      case ({s.awAddr[7:2], 2'b00})
        `NSW_OFS_CTRL: begin
          cur = laneMerge({31'h0, s.ext}, s.wData, s.wStrb);
          next_s.ext = cur[`NSW_CTRL_EXT];
        end
        `NSW_OFS_POINTER: begin
          cur = laneMerge({11'h0, s.ptr}, s.wData, s.wStrb);
          if (!busy) begin
            next_s.ptr = cur[20:0];
          end
        end
        `NSW_OFS_WREG: begin
          cur = laneMerge({24'h0, s.wreg}, s.wData, s.wStrb);
          if (!busy) begin
            next_s.wreg = cur[7:0];
          end
        end
        `NSW_OFS_BANK: begin
          cur = laneMerge({28'h0, s.bankSel}, s.wData, s.wStrb);
          if (!busy) begin
            next_s.bankSel = cur[3:0];
          end
        end
        `NSW_OFS_LATCH, `NSW_OFS_STAT: begin
          next_s.bResp = `NSW_RESP_OK; // read-only slots: write dropped
        end
        default: begin
          next_s.bResp = `NSW_RESP_ERR;
        end
      endcase
    end
    if (s.bValid && axiReq.bready) begin
      next_s.bValid = 1'b0;
    end

    // AXI read: answer one cycle after the address is taken
    if (s.rValid) begin
      if (axiReq.rready) begin
        next_s.rValid = 1'b0;
      end
    end else if (axiReq.arvalid) begin
      next_s.rValid = 1'b1;
      next_s.rResp  = `NSW_RESP_OK;
      case ({axiReq.araddr[7:2], 2'b00})
        `NSW_OFS_CTRL:   next_s.rData = {31'h0, s.ext};
        `NSW_OFS_POINTER: next_s.rData = {11'h0, s.ptr};
        `NSW_OFS_LATCH:   next_s.rData = {24'h0, s.tableLatch};
        `NSW_OFS_WREG:    next_s.rData = {24'h0, s.wreg};
        `NSW_OFS_BANK:    next_s.rData = {28'h0, s.bankSel};
        `NSW_OFS_STAT:   next_s.rData = {31'h0, busy};
        default: begin
          next_s.rData = 32'h0;
          next_s.rResp = `NSW_RESP_ERR;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s            <= '0;
      s.ptr        <= `NSW_RST_PTR;
      s.tableLatch <= `NSW_RST_BYTE;
      s.wreg       <= `NSW_RST_BYTE;
      s.bankSel    <= `NSW_RST_BANK;
    end else begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_swap_nibbles: assert property (
    (s.st == ST_SWAP && s.q == 2'd1) |-> ##2 (s.res == $past(swpRef, 2)))
    else $error("swap result does not exchange nibbles");

  a_dest_file: assert property (
    (s.st == ST_SWAP && s.q == 2'd2 && s.d) |=> (fileWe && fileWdata == s.res)
      ##1 !fileWe)
    else $error("file write-back missing for destination one");

  a_dest_wreg: assert property (
    (s.st == ST_SWAP && s.q == 2'd3 && !s.d) |=> (wreg == $past(s.res)))
    else $error("working register not loaded for destination zero");

  a_bank_addr: assert property (
    (s.st == ST_SWAP && s.q == 2'd1 && s.a) |-> (fileAddr == {s.bankSel, s.f}) && fileRe)
    else $error("banked file address wrong");

  a_indexed_addr: assert property (
    (swapAcc && !instrWord[8] && s.ext && instrWord[7:0] <= 8'h5f)
      |=> (fileAddr == $past(idxBase) + {4'h0, $past(instrWord[7:0])}))
    else $error("indexed literal offset address wrong");

  a_post_adjust: assert property (
    (s.st == ST_TBL2 && s.q == 2'd3 && s.adjCode[1] != s.adjCode[0])
      |=> (s.ptr == ($past(s.adjCode) == 2'd1 ? $past(s.ptr) + 21'd1
                                          : $past(s.ptr) - 21'd1)))
    else $error("post adjust of table pointer wrong");

  a_pre_incr: assert property (
    (s.st == ST_TBL1 && s.q == 2'd3 && s.adjCode == 2'd3)
      |=> (s.ptr == $past(s.ptr) + 21'd1) && (s.rdPtr == s.ptr) && pmRe)
    else $error("pre increment not applied before read");

  a_ptr_wrap: assert property (
    (s.st == ST_TBL2 && s.q == 2'd3 && s.adjCode == 2'd2 && s.ptr == 21'h0)
      |=> (s.ptr == 21'h1fffff))
    else $error("table pointer does not wrap in 21 bits");

  a_latch_byte: assert property (
    (s.st == ST_TBL2 && s.q == 2'd1) |-> ##3 (s.tableLatch == $past(pmByte, 3)))
    else $error("table latch byte select wrong");

  a_tbl_timing: assert property (
    tblAcc |=> (s.st == ST_TBL1)[*3] ##1 (s.st == ST_TBL2 && pmRe)[*2]
      ##1 (s.st == ST_TBL2 && !pmRe)[*2] ##1 (s.st == ST_IDLE))
    else $error("table read does not take two cycles");

  a_swap_timing: assert property (
    swapAcc |=> (s.st == ST_SWAP)[*3] ##1 (s.st == ST_IDLE && instrReady))
    else $error("swap does not finish in one cycle");

  a_no_flags: assert property (
    (s.st != ST_IDLE) |-> !flagWe)
    else $error("status flags written");

endmodule : nsw_core

// File: src/nsw_pkg.sv
// types shared by the nibble swap / table read unit
// assumes nsw_regs.svh supplies the numeric constants
package nsw_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SWAP, ST_TBL1, ST_TBL2} nswPhase_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } nswAxiReq_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } nswAxiRsp_t;
endpackage : nsw_pkg

// File: src/nsw_regs.svh
// register offsets, reset values and timing counts of the nibble swap / table read unit
// assumes a 200 MHz sys_clk and AXI4-Lite word addressing
`ifndef NSW_REGS_SVH
`define NSW_REGS_SVH
// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define NSW_OFS_CTRL   8'h00
`define NSW_OFS_POINTER 8'h04
`define NSW_OFS_LATCH  8'h08
`define NSW_OFS_WREG   8'h0c
`define NSW_OFS_BANK   8'h10
`define NSW_OFS_STAT   8'h14
// field positions and reset values
`define NSW_CTRL_EXT   0
`define NSW_STAT_BUSY  0
`define NSW_RST_PTR    21'h000000
`define NSW_RST_BYTE   8'h00
`define NSW_RST_BANK   4'h0
// opcode patterns and addressing limits
`define NSW_OP_SWAP    6'h0e
`define NSW_OP_TREAD   14'h0002
`define NSW_IDX_LIMIT  8'h5f
`define NSW_ACC_SPLIT  8'h60
`define NSW_SFR_PAGE   4'hf
// quarter phases per instruction cycle
`define NSW_QUARTERS   4
`define NSW_RESP_OK    2'h0
`define NSW_RESP_ERR   2'h2
`endif

// File: tb/nsw_mem.sv
// behavioural register file and program memory facing nsw_core
// assumes answers are wanted combinationally within each strobed cycle
`timescale 1ns/10ps
module nsw_mem (
  input  wire logic        sys_clk,
  input  wire logic [11:0] fileAddr,
  input  wire logic        fileRe,
  output logic [7:0]       fileRdata,
  input  wire logic [7:0]  fileWdata,
  input  wire logic        fileWe,
  input  wire logic [19:0] pmWordAddr,
  input  wire logic        pmRe,
  output logic [15:0]      pmRdata
);
  logic [7:0] regs [4096];
  logic [7:0] noise;
  // preload: each location a known function of its address
  initial begin
    for (int i = 0; i < 4096; i++) begin
      regs[i] = i[7:0] ^ 8'h3c;
    end
    noise = 8'h00;
  end
  // write-back; noise moves every cycle so a stale read never matches
  always @(posedge sys_clk) begin
    noise <= noise + 8'h35;
    if (fileWe) begin
      regs[fileAddr] <= fileWdata;
    end
  end
  // data only while strobed, otherwise a changing pattern
  assign fileRdata = fileRe ? regs[fileAddr] : noise;
  assign pmRdata = pmRe ? {pmWordAddr[7:0] ^ 8'ha5, pmWordAddr[15:8] + 8'h11} : {noise, ~noise};
endmodule : nsw_mem

// File: tb/tb_top.sv
// self-checking bench for nsw_core: axi register tasks plus instruction issue
// assumes nsw_mem stands in for the register file and program memory
`timescale 1ns/10ps
`include "nsw_regs.svh"
module tb_top
  import nsw_pkg::*;
;
  logic        sys_clk, rst_n, instrValid, instrReady, fileRe, fileWe, pmRe, flagWe;
  nswAxiReq_t  req;
  nswAxiRsp_t  rsp;
  logic [15:0] instrWord, pmRdata;
  logic [11:0] fileAddr, idxBase;
  logic [7:0]  fileRdata, fileWdata, wreg;
  logic [19:0] pmWordAddr;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          nErrors, comparisons;

  nsw_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp),
    .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
    .fileAddr(fileAddr), .fileRe(fileRe), .fileRdata(fileRdata), .fileWdata(fileWdata),
    .fileWe(fileWe), .idxBase(idxBase), .pmWordAddr(pmWordAddr), .pmRe(pmRe),
    .pmRdata(pmRdata), .wreg(wreg), .flagWe(flagWe));
  nsw_mem i_mem (.sys_clk(sys_clk), .fileAddr(fileAddr), .fileRe(fileRe),
    .fileRdata(fileRdata), .fileWdata(fileWdata), .fileWe(fileWe),
    .pmWordAddr(pmWordAddr), .pmRe(pmRe), .pmRdata(pmRdata));

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkResp
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // a wait that ran out of its bound ends the run
  task automatic expire;
    nErrors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask : expire
  // address, data and bready offered together; each released once taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aHit, wHit, bHit;
    bHit = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    for (int i = 0; i < 40 && !bHit; i++) begin
      #1;
      aHit = req.awvalid & rsp.awready;
      wHit = req.wvalid & rsp.wready;
      bHit = rsp.bvalid;
      r = rsp.bresp;
      @(posedge sys_clk);
      if (aHit) req.awvalid <= 1'b0;
      if (wHit) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    // one idle edge so a following call never re-drives bready in this step
    @(posedge sys_clk);
    if (!bHit) expire();
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aHit, rHit;
    rHit = 1'b0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (int i = 0; i < 40 && !rHit; i++) begin
      #1;
      aHit = req.arvalid & rsp.arready;
      rHit = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge sys_clk);
      if (aHit) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    // one idle edge so a following call never re-drives rready in this step
    @(posedge sys_clk);
    if (!rHit) expire();
  endtask : axiRd
  // offer an instruction until the Q1 slot takes it; returns at the accept edge
  task automatic issue(input logic [15:0] w);
    logic ok;
    ok = 1'b0;
    instrValid <= 1'b1;
    instrWord  <= w;
    for (int i = 0; i < 12 && !ok; i++) begin
      #1;
      ok = instrReady;
      @(posedge sys_clk);
    end
    instrValid <= 1'b0;
    if (!ok) expire();
  endtask : issue

  // ----------------------------------------
  // instruction scenarios
  // ----------------------------------------
  task automatic swap(input logic d, input logic a, input logic [7:0] f, input logic [11:0] ea);
    logic [7:0] src, res, w0;
    src = i_mem.regs[ea];
    res = {src[3:0], src[7:4]};
    w0 = wreg;
    issue({6'h0e, d, a, f});
    #1;
    chk({20'h0, fileAddr}, {20'h0, ea});
    chk({31'h0, fileRe}, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({31'h0, fileWe}, {31'h0, d});
    @(posedge sys_clk);
    #1;
    chk({24'h0, i_mem.regs[ea]}, {24'h0, d ? res : src});
    chk({24'h0, wreg}, {24'h0, d ? w0 : res});
    @(posedge sys_clk);
  endtask : swap
  // byte of the word at rp: bit 0 picks the high byte
  task automatic tread(input logic [1:0] adjCode, input logic [20:0] p0);
    logic [20:0] rp, pEnd;
    logic [7:0]  b;
    axiWr(`NSW_OFS_POINTER, {11'h0, p0}, rs);
    rp = (adjCode == 2'd3) ? p0 + 21'd1 : p0;
    pEnd = (adjCode == 2'd2) ? p0 - 21'd1 : (adjCode[0] ? p0 + 21'd1 : p0);
    b = rp[0] ? (rp[8:1] ^ 8'ha5) : (rp[16:9] + 8'h11);
    issue({14'h0002, adjCode});
    repeat (4) @(posedge sys_clk);
    #1;
    chk({31'h0, pmRe}, 32'h1);
    chk({12'h0, pmWordAddr}, {12'h0, rp[20:1]});
    @(posedge sys_clk);
    #1;
    chk({31'h0, pmRe}, 32'h0);
    repeat (2) @(posedge sys_clk);
    axiRd(`NSW_OFS_LATCH, rd, rs);
    chk(rd, {24'h0, b});
    axiRd(`NSW_OFS_POINTER, rd, rs);
    chk(rd, {11'h0, pEnd});
  endtask : tread

  // flag writes must never appear
  always @(negedge sys_clk) begin
    if (rst_n) chk({31'h0, flagWe}, 32'h0);
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    instrWord = 16'h0000;
    instrValid = 1'b0;
    idxBase = 12'h123;
    nErrors = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped slot
    for (int k = 0; k < 7; k++) begin
      axiRd(8'(k * 4), rd, rs);
      chk(rd, 32'h0);
      chkResp(rs, (k == 6) ? `NSW_RESP_ERR : `NSW_RESP_OK);
    end
    axiWr(8'h18, 32'h0, rs);
    chkResp(rs, `NSW_RESP_ERR);
    $display("test done: reset and map");
    axiWr(`NSW_OFS_BANK, 32'h2, rs);
    swap(1'b1, 1'b1, 8'h53, 12'h253);
    swap(1'b0, 1'b1, 8'h9a, 12'h29a);
    swap(1'b1, 1'b0, 8'h10, 12'h010);
    swap(1'b0, 1'b0, 8'h70, 12'hf70);
    axiRd(`NSW_OFS_WREG, rd, rs);
    chk(rd, 32'h000000c4); // last swap: 4c from the preload
    $display("test done: swap banks");
    axiWr(`NSW_OFS_CTRL, 32'h1, rs);
    swap(1'b0, 1'b0, 8'h05, 12'h128);
    swap(1'b1, 1'b0, 8'h5f, 12'h182);
    swap(1'b0, 1'b0, 8'h60, 12'hf60);
    swap(1'b1, 1'b1, 8'h05, 12'h205);
    $display("test done: indexed offset");
    for (int k = 0; k < 4; k++) begin
      tread(2'(k), 21'h00a356 + 21'(k));
    end
    tread(2'd1, 21'h1fffff);
    tread(2'd2, 21'h000000);
    tread(2'd3, 21'h01a357);
    axiWr(`NSW_OFS_LATCH, 32'hff, rs);
    chkResp(rs, `NSW_RESP_OK);
    axiRd(`NSW_OFS_LATCH, rd, rs);
    // latch keeps the low byte of word d1ac; the bus write is dropped
    chk(rd, 32'h000000e2);
    $display("test done: table read");
    conclude();
  end
endmodule : tb_top
